// ===== src/tscb_pkg.sv
// Constants and types for the test signal configuration bank
// Functional notes
// - Bit-pick field selects one bit of the chosen test bus onto card link pin
// - Reorder bit maps test bus bits 4,3,2,6,5,0 onto parallel pins
// - PRBS9 bit enables the 9-bit pseudo-random generator as transmit source
// - PRBS15 bit enables the 15-bit pseudo-random generator as transmit source
// - An enabled sequence starts transmitting only after the send command
// - Group-pick field chooses which internal test bus is observable
// - UART line enable at zero disables both auxiliary UART lines
// - Driver enable bit n turns on output driver of parallel pin n
// - With SPI host active only parallel pins 1 to 4 may drive
// - With UART host and its lines enabled only pins 1 to 4 drive
// - Pin-enable register resets to 80h
// - Test-selection register resets to 00h
// - Register at 30h has no function, reads zero
// - In GPIO mode enabled pins drive the matching pin value bits
package tscb_pkg;

  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned TBUS_W  = 8;
  localparam int unsigned TBUS_N  = 32;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_RSVD    = 6'h30;
  localparam logic [5:0] IDX_SEL1    = 6'h31;
  localparam logic [5:0] IDX_SEL2    = 6'h32;
  localparam logic [5:0] IDX_PINEN   = 6'h33;
  localparam logic [5:0] IDX_PINVAL  = 6'h34;
  localparam logic [5:0] IDX_HOSTCTL = 6'h3C;

  localparam logic [7:0] RST_SEL1    = 8'h00;
  localparam logic [7:0] RST_SEL2    = 8'h00;
  localparam logic [7:0] RST_PINEN   = 8'h80;
  localparam logic [7:0] RST_PINVAL  = 8'h00;
  localparam logic [7:0] RST_HOSTCTL = 8'h00;

  // Field positions
  localparam int unsigned SEL2_REORDER = 7;
  localparam int unsigned SEL2_PRBS9   = 6;
  localparam int unsigned SEL2_PRBS15  = 5;
  localparam int unsigned PINEN_UART   = 7;
  localparam int unsigned PINVAL_GPIO  = 7;
  localparam int unsigned HOST_SEND    = 0;
  localparam int unsigned HOST_MODE_LO = 1;
  localparam int unsigned HOST_BUSY    = 7;

  // Highest pin usable while a serial host owns the upper pins
  localparam int unsigned LIMITED_PIN_MAX = 4;

  // Feedback taps, counted from bit zero
  localparam int unsigned PRBS9_TAP_A  = 8;
  localparam int unsigned PRBS9_TAP_B  = 4;
  localparam int unsigned PRBS15_TAP_A = 14;
  localparam int unsigned PRBS15_TAP_B = 13;
  localparam logic [14:0] PRBS_SEED    = 15'h7FFF;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    HOST_I2C  = 2'h0,
    HOST_SPI  = 2'h1,
    HOST_UART = 2'h2
  } tscb_host_t;

  typedef enum logic {
    WR_COLLECT = 1'b0,
    WR_RESP    = 1'b1
  } tscb_wr_t;

  typedef enum logic {
    RD_IDLE = 1'b0,
    RD_RESP = 1'b1
  } tscb_rd_t;

endpackage

// ===== src/tscb_prbs.sv
// Pseudo-random bit sequence generator, 9 or 15 bit, one bit per clock
`timescale 1ns/1ps
module tscb_prbs
  import tscb_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic prbs9_en,
  input  wire logic prbs15_en,
  input  wire logic send,
  output logic      tx_bit,
  output logic      tx_valid
);

  typedef struct packed {
    logic [14:0] lfsr;
    logic        active;
    logic        bit_q;
  } tscb_prbs_st_t;

  localparam tscb_prbs_st_t RST_ST = '{lfsr: PRBS_SEED, active: 1'b0,
                                       bit_q: 1'b0};

  tscb_prbs_st_t q;
  tscb_prbs_st_t d;
  logic          fb;

  always_comb begin
    d  = q;
    fb = 1'b0;
    if (!(prbs9_en || prbs15_en)) begin
      // Leaving both modes rewinds so the next run is repeatable
      d.active = 1'b0;
      d.lfsr   = PRBS_SEED;
    end else if (send) begin
      d.active = 1'b1;
    end
    if (q.active) begin
      // Both enables set is undefined; the shorter sequence wins
      if (prbs9_en) begin
        fb      = q.lfsr[PRBS9_TAP_A] ^ q.lfsr[PRBS9_TAP_B];
        d.bit_q = q.lfsr[PRBS9_TAP_A];
        d.lfsr  = {6'h00, q.lfsr[7:0], fb};
      end else begin
        fb      = q.lfsr[PRBS15_TAP_A] ^ q.lfsr[PRBS15_TAP_B];
        d.bit_q = q.lfsr[PRBS15_TAP_A];
        d.lfsr  = {q.lfsr[13:0], fb};
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= RST_ST;
    end else begin
      q <= d;
    end
  end

  assign tx_bit   = q.bit_q;
  assign tx_valid = q.active;

endmodule // tscb_prbs

// ===== src/tscb_top.sv
// Test signal configuration bank with AXI4-Lite register access
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
module tscb_top
  import tscb_pkg::*;
(
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [ADDR_W-1:0]         s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [DATA_W-1:0]         s_axi_wdata,
  input  wire logic [DATA_W/8-1:0]       s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [ADDR_W-1:0]         s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [DATA_W-1:0]              s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic [TBUS_N*TBUS_W-1:0]  test_bus_groups,
  output logic                           card_link_out_pin,
  input  wire logic [6:1]                parallel_port_pins_i,
  output logic [6:1]                     parallel_port_pins_o,
  output logic [6:1]                     parallel_port_pins_oe,
  input  wire logic                      uart_extra_src,
  input  wire logic                      uart_request_src,
  output logic                           uart_extra_out_line,
  output logic                           uart_request_line,
  output logic                           uart_lines_oe,
  output logic                           prbs_tx_bit,
  output logic                           prbs_tx_valid
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    // Write channel
    tscb_wr_t   wst;
    logic       aw_have;
    logic       w_have;
    logic [5:0] waddr;
    logic [7:0] wdata;
    logic       wstrb0;
    logic [1:0] bresp;
    // Read channel
    tscb_rd_t   rst;
    logic [7:0] rdata;
    logic [1:0] rresp;
    // Software-visible fields
    logic [2:0] bit_pick;
    logic [7:0] sel2;
    logic       uart_en;
    logic [6:1] pin_en;
    logic       gpio;
    logic [6:1] pin_val;
    tscb_host_t host;
    logic       send;
    // Output flops and pin synchroniser
    logic       card_out;
    logic [6:1] pin_o;
    logic [6:1] pin_oe;
    logic [6:1] pin_s1;
    logic [6:1] pin_s2;
    logic       uart_extra;
    logic       uart_req;
    logic       uart_oe;
  } tscb_st_t;

  localparam tscb_st_t RST_ST = '{
    wst:        WR_COLLECT,
    aw_have:    1'b0,
    w_have:     1'b0,
    waddr:      6'h00,
    wdata:      8'h00,
    wstrb0:     1'b0,
    bresp:      RESP_OKAY,
    rst:        RD_IDLE,
    rdata:      8'h00,
    rresp:      RESP_OKAY,
    bit_pick:   RST_SEL1[2:0],
    sel2:       RST_SEL2,
    uart_en:    RST_PINEN[PINEN_UART],
    pin_en:     RST_PINEN[6:1],
    gpio:       RST_PINVAL[PINVAL_GPIO],
    pin_val:    RST_PINVAL[6:1],
    host:       tscb_host_t'(RST_HOSTCTL[2:1]),
    send:       1'b0,
    card_out:   1'b0,
    pin_o:      6'h00,
    pin_oe:     6'h00,
    pin_s1:     6'h00,
    pin_s2:     6'h00,
    uart_extra: 1'b0,
    uart_req:   1'b0,
    uart_oe:    1'b0
  };

  tscb_st_t           q;
  tscb_st_t           d;
  logic               aw_fire;
  logic               w_fire;
  logic [TBUS_W-1:0]  grp;
  logic               prbs_busy;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Registers are one word apart, so the two low address bits are ignored
  function automatic logic [5:0] word_index(input logic [ADDR_W-1:0] addr);
    word_index = addr[7:2];
  endfunction

  // Unmapped indices answer with an error response
  function automatic logic is_mapped(input logic [5:0] idx);
    is_mapped = (idx == IDX_RSVD) || (idx == IDX_SEL1) ||
                (idx == IDX_SEL2) || (idx == IDX_PINEN) ||
                (idx == IDX_PINVAL) || (idx == IDX_HOSTCTL);
  endfunction

  // Pin n may drive unless a serial host has claimed the upper pins
  function automatic logic pin_allowed(input int unsigned n,
                                       input tscb_host_t h,
                                       input logic uart_en);
    logic limited;
    limited = (h == HOST_SPI) || ((h == HOST_UART) && uart_en);
    pin_allowed = !limited || (n <= LIMITED_PIN_MAX);
  endfunction

  // Reordered view: pins 6..1 carry bus bits 4,3,2,6,5,0
  function automatic logic flip_bit(input logic [TBUS_W-1:0] b,
                                    input int unsigned n);
    case (n)
      6:       flip_bit = b[4];
      5:       flip_bit = b[3];
      4:       flip_bit = b[2];
      3:       flip_bit = b[6];
      2:       flip_bit = b[5];
      default: flip_bit = b[0];
    endcase
  endfunction

  // GPIO mode takes the pin over from the test bus entirely
  function automatic logic pin_source(input int unsigned       n,
                                      input logic              gpio,
                                      input logic              reorder,
                                      input logic [6:1]        val,
                                      input logic [TBUS_W-1:0] b);
    if (gpio) begin
      pin_source = val[n];
    end else if (reorder) begin
      pin_source = flip_bit(b, n);
    end else begin
      pin_source = b[n];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sequence generator

  tscb_prbs u_prbs (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .prbs9_en  (q.sel2[SEL2_PRBS9]),
    .prbs15_en (q.sel2[SEL2_PRBS15]),
    .send      (q.send),
    .tx_bit    (prbs_tx_bit),
    .tx_valid  (prbs_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  assign s_axi_awready = (q.wst == WR_COLLECT) && !q.aw_have;
  assign s_axi_wready  = (q.wst == WR_COLLECT) && !q.w_have;
  assign aw_fire       = s_axi_awvalid && s_axi_awready;
  assign w_fire        = s_axi_wvalid && s_axi_wready;
  // Plain mux: the test bus groups run on this clock
  assign grp = test_bus_groups[32'(q.sel2[4:0]) * TBUS_W +: TBUS_W];

  always_comb begin
    d        = q;
    d.send   = 1'b0;
    d.pin_s1 = parallel_port_pins_i;
    d.pin_s2 = q.pin_s1;

    // AW and W may come in either order; the store waits for both
    unique case (q.wst)
      WR_COLLECT: begin
        if (aw_fire) begin
          d.aw_have = 1'b1;
          d.waddr   = word_index(s_axi_awaddr);
        end
        if (w_fire) begin
          d.w_have = 1'b1;
          d.wdata  = s_axi_wdata[7:0];
          d.wstrb0 = s_axi_wstrb[0];
        end
        if (d.aw_have && d.w_have) begin
          d.aw_have = 1'b0;
          d.w_have  = 1'b0;
          d.wst     = WR_RESP;
          d.bresp   = is_mapped(d.waddr) ? RESP_OKAY : RESP_SLVERR;
          // Only the low byte lane holds register bits
          if (d.wstrb0) begin
            unique case (d.waddr)
              IDX_SEL1: d.bit_pick = d.wdata[2:0];
              IDX_SEL2: d.sel2 = d.wdata;
              IDX_PINEN: begin
                d.uart_en = d.wdata[PINEN_UART];
                d.pin_en  = d.wdata[6:1];
              end
              IDX_PINVAL: begin
                d.gpio    = d.wdata[PINVAL_GPIO];
                d.pin_val = d.wdata[6:1];
              end
              IDX_HOSTCTL: begin
                d.host = tscb_host_t'(d.wdata[HOST_MODE_LO +: 2]);
                d.send = d.wdata[HOST_SEND];
              end
              default: d.send = 1'b0;
            endcase
          end
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          d.wst = WR_COLLECT;
        end
      end
    endcase

    // Read data is captured when the address is taken
    unique case (q.rst)
      RD_IDLE: begin
        if (s_axi_arvalid) begin
          d.rst   = RD_RESP;
          d.rresp = is_mapped(word_index(s_axi_araddr)) ?
                    RESP_OKAY : RESP_SLVERR;
          unique case (word_index(s_axi_araddr))
            IDX_SEL1:    d.rdata = {5'h00, q.bit_pick};
            IDX_SEL2:    d.rdata = q.sel2;
            IDX_PINEN:   d.rdata = {q.uart_en, q.pin_en, 1'b0};
            IDX_PINVAL:  d.rdata = {q.gpio,
                                    q.gpio ? q.pin_s2 : q.pin_val, 1'b0};
            IDX_HOSTCTL: d.rdata = {prbs_busy, 4'h0, q.host, 1'b0};
            default:     d.rdata = 8'h00;
          endcase
        end
      end
      RD_RESP: begin
        if (s_axi_rready) begin
          d.rst = RD_IDLE;
        end
      end
    endcase

    // Outputs follow the settings one clock later
    d.card_out = grp[q.bit_pick];
    for (int unsigned n = 1; n <= 6; n++) begin
      d.pin_o[n]  = pin_source(n, q.gpio, q.sel2[SEL2_REORDER], q.pin_val,
                               grp);
      d.pin_oe[n] = q.pin_en[n] && pin_allowed(n, q.host, q.uart_en);
    end
    // Gated rather than muxed, so a disabled line idles low
    d.uart_oe    = q.uart_en;
    d.uart_extra = q.uart_en && uart_extra_src;
    d.uart_req   = q.uart_en && uart_request_src;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= RST_ST;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign s_axi_bvalid          = (q.wst == WR_RESP);
  assign s_axi_bresp           = q.bresp;
  assign s_axi_arready         = (q.rst == RD_IDLE);
  assign s_axi_rvalid          = (q.rst == RD_RESP);
  assign s_axi_rresp           = q.rresp;
  assign s_axi_rdata           = {24'h000000, q.rdata};
  assign card_link_out_pin     = q.card_out;
  assign parallel_port_pins_o  = q.pin_o;
  assign parallel_port_pins_oe = q.pin_oe;
  assign uart_extra_out_line   = q.uart_extra;
  assign uart_request_line     = q.uart_req;
  assign uart_lines_oe         = q.uart_oe;
  assign prbs_tx_valid         = prbs_busy;

endmodule // tscb_top

// ===== tb/test_signal_config_bank_tb.sv
// Directed register and pin tests for the test signal bank
`timescale 1ns/1ps
module test_signal_config_bank_tb
  import tscb_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, card_link_out_pin;
  logic uart_extra_src, uart_request_src, uart_extra_out_line;
  logic uart_request_line, uart_lines_oe, prbs_tx_bit, prbs_tx_valid;
  logic [ADDR_W-1:0]        s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0]        s_axi_wdata, s_axi_rdata;
  logic [DATA_W/8-1:0]      s_axi_wstrb;
  logic [1:0]               s_axi_bresp, s_axi_rresp, last_b;
  logic [TBUS_N*TBUS_W-1:0] test_bus_groups;
  logic [6:1]               parallel_port_pins_i, parallel_port_pins_o;
  logic [6:1]               parallel_port_pins_oe;
  logic [7:0]               grp;
  int                       n_errors = 0, n_compared = 0, cyc = 0;

  tscb_top dut (.*);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under 2000 cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Ready is looked at mid-cycle, so it is settled before the taking edge
  task automatic wr(logic [7:0] a, logic [31:0] d);
    bit da, dw, ga, gw, gb;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    da = 1'b0;
    dw = 1'b0;
    while (!(da && dw)) begin
      @(negedge aclk);
      ga = s_axi_awvalid && s_axi_awready;
      gw = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (ga) s_axi_awvalid <= 1'b0;
      if (gw) s_axi_wvalid <= 1'b0;
      da |= ga;
      dw |= gw;
    end
    do begin
      @(negedge aclk);
      gb = s_axi_bvalid;
      last_b = s_axi_bresp;
      @(posedge aclk);
    end while (!gb);
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e, logic [1:0] er = 2'h0);
    bit g;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      g = s_axi_arready;
      @(posedge aclk);
    end while (!g);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      g = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
    end while (!g);
    check($sformatf("rdata %h", a), d, e);
    check($sformatf("rresp %h", a), r, er);
  endtask

  task automatic settle;
    repeat (3) @(negedge aclk);
  endtask

  task automatic prbs(logic [7:0] mode, int l, int m);
    logic [39:0] s;
    int bad;
    wr(8'hF0, 32'h1);
    settle;
    check("send no mode", prbs_tx_valid, 1'b0);
    wr(8'hC8, mode);
    settle;
    check("armed idle", prbs_tx_valid, 1'b0);
    wr(8'hF0, 32'h1);
    bad = 0;
    repeat (3) @(negedge aclk);
    for (int i = 0; i < 40; i++) begin
      s[i] = prbs_tx_bit;
      if (i >= l && s[i] !== (s[i-l] ^ s[i-m])) bad++;
      @(negedge aclk);
    end
    check("running", prbs_tx_valid, 1'b1);
    check("sequence", bad, 0);
    check("not stuck", s != '1 && s != '0, 1'b1);
    wr(8'hC8, 32'h0);
    settle;
    check("stopped", prbs_tx_valid, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_bready, s_axi_rready, uart_extra_src, uart_request_src} = 4'hF;
    s_axi_wstrb = 4'hF;
    parallel_port_pins_i = 6'h00;
    for (int g = 0; g < TBUS_N; g++)
      test_bus_groups[8*g +: 8] = 8'(g * 29 + 91);
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'hC0, 32'h0);
    rd(8'hC4, 32'h0);
    rd(8'hC8, 32'h0);
    rd(8'hCC, 32'h80);
    rd(8'hF4, 32'h0, RESP_SLVERR);
    wr(8'hC0, 32'hFF);
    rd(8'hC0, 32'h0);
    wr(8'hC4, 32'hFF);
    rd(8'hC4, 32'h07);
    wr(8'hCC, 32'hFF);
    rd(8'hCC, 32'hFE);
    wr(8'hF4, 32'h1);
    check("bresp", last_b, RESP_SLVERR);
    for (int g = 1; g < TBUS_N; g += 10) begin
      wr(8'hC8, 32'(g));
      for (int b = 0; b < 8; b++) begin
        wr(8'hC4, 32'(b));
        settle;
        check("card pin", card_link_out_pin, test_bus_groups[8*g+b]);
      end
    end
    grp = test_bus_groups[8*31 +: 8];
    check("pins", parallel_port_pins_o, grp[6:1]);
    check("oe", parallel_port_pins_oe, 6'h3F);
    check("uart on", {uart_lines_oe, uart_extra_out_line,
                      uart_request_line}, 3'h7);
    @(posedge aclk);
    uart_extra_src <= 1'b0;
    settle;
    check("uart src", {uart_extra_out_line, uart_request_line}, 2'h1);
    @(posedge aclk);
    uart_extra_src <= 1'b1;
    s_axi_wstrb    <= 4'hE;
    wr(8'hC4, 32'h2);
    s_axi_wstrb <= 4'hF;
    check("bresp ok", last_b, RESP_OKAY);
    rd(8'hC4, 32'h07);
    wr(8'hC8, 32'h9F);
    settle;
    check("reorder", parallel_port_pins_o,
          {grp[4], grp[3], grp[2], grp[6], grp[5], grp[0]});
    wr(8'hF0, 32'h2);
    settle;
    check("spi oe", parallel_port_pins_oe, 6'h0F);
    wr(8'hF0, 32'h4);
    settle;
    check("uart oe", parallel_port_pins_oe, 6'h0F);
    wr(8'hCC, 32'h7E);
    settle;
    check("uart free oe", parallel_port_pins_oe, 6'h3F);
    check("uart off", {uart_lines_oe, uart_extra_out_line,
                       uart_request_line}, 3'h0);
    wr(8'hD0, 32'hD4);
    settle;
    check("gpio", parallel_port_pins_o, 6'h2A);
    @(posedge aclk);
    parallel_port_pins_i <= 6'h15;
    settle;
    rd(8'hD0, 32'hAA);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'hC8, 32'h0);
    rd(8'hCC, 32'h80);
    check("reset oe", parallel_port_pins_oe, 6'h00);
    check("reset uart", uart_lines_oe, 1'b1);
    prbs(8'h40, 9, 5);
    prbs(8'h20, 15, 14);
    end_of_test();
  end
endmodule // test_signal_config_bank_tb

// ===== tb/tscb_properties.sv
// Bus handshake and auxiliary line checks for the test signal bank
`timescale 1ns/1ps
module tscb_properties
  import tscb_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              uart_extra_out_line,
  input wire logic              uart_request_line,
  input wire logic              uart_lines_oe
);
  logic mapped;
  assign mapped = (s_axi_araddr[7:2] >= IDX_RSVD
                   && s_axi_araddr[7:2] <= IDX_PINVAL)
                  || s_axi_araddr[7:2] == IDX_HOSTCTL;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar_take; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_b_done; s_axi_bvalid && s_axi_bready; endsequence
  sequence s_wr_open; !s_axi_bvalid && s_axi_awready && s_axi_wready;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_ar_take |=> s_axi_rvalid)
    else $error("read response late");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready
    && !s_axi_wready) else $error("write taken during response");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  a_b_release: assert property (s_b_done |=> s_wr_open)
    else $error("write channel not reopened");
  a_r_release: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid && s_axi_arready) else $error("read not reopened");
  // Upper bytes must stay clear: registers are one byte wide
  a_read_ok: assert property (s_ar_take ##0 mapped |=>
    s_axi_rresp == RESP_OKAY && s_axi_rdata[31:8] == 24'h0)
    else $error("mapped read answered badly");
  a_read_err: assert property (s_ar_take ##0 !mapped |=>
    s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_uart_off: assert property (!uart_lines_oe |-> !uart_extra_out_line
    && !uart_request_line)
    else $error("uart line active while disabled");
endmodule // tscb_properties

bind tscb_top tscb_properties u_props (.*);
